// File: design/flow_guard_pkg.sv
package flow_guard_pkg;

   // privilege level that selects the user tracker
   localparam logic [1:0] USER_PRIVILEGE_LEVEL = 2'h3;

   // tracker indices inside the tracker arrays
   localparam int TRACKER_SUPERVISOR = 0;
   localparam int TRACKER_USER = 1;

   // tracker state: idle, or waiting for a landing pad
   typedef enum logic {
      TRACKER_IDLE = 1'b0,
      await_landing_pad_state = 1'b1
   } tracker_state_t;

   // kind of the instruction or event retired this cycle
   typedef enum logic [2:0] {
      RETIRE_OTHER = 3'b000,
      RETIRE_NEAR_INDIRECT = 3'b001,
      RETIRE_FAR_BRANCH = 3'b010,
      RETIRE_SYSTEM_ENTRY = 3'b011,
      RETIRE_EVENT = 3'b100,
      RETIRE_INTERRUPT_RETURN = 3'b101,
      RETIRE_LANDING_PAD_32 = 3'b110,
      RETIRE_LANDING_PAD_64 = 3'b111
   } retire_kind_t;

   // one privilege class's tracking configuration
   typedef struct packed {
      logic enable;
      logic tracker_bit_a;
      logic tracker_bit_a_disable;
   } flow_guard_cfg_t;

   // reset values
   localparam tracker_state_t RESET_TRACKER_STATE = TRACKER_IDLE;
   localparam logic RESET_TRACKER_BIT_A = 1'b0;
   localparam logic [63:0] RESET_FAULT_IP = 64'h0000_0000_0000_0000;

endpackage : flow_guard_pkg

// File: design/indirect_branch_tracker.sv
`timescale 1ns/1ps

// Behaviour
// - enabled needs master, protected, no v86, enable
// - user config at level 3, else supervisor
// - active test also needs tracker_bit_a bit clear
// - two trackers: user and supervisor, idle/waiting
// - privilege class picks the single active tracker
// - class change: source kept, destination only without fault
// - cross-class far/system entry: destination waits, unsuppressed
// - interrupt or exception into an enabled class: destination waits, unsuppressed
// - cross-class return resumes retained tracker state
// - same-class return leaves tracker unchanged
// - same-class far branch: waits, unsuppressed
// - near indirect waits only if enabled, unsuppressed
// - landing pad width follows 64-bit mode
// - both trackers idle after reset
// - waiting and neither landing pad nor event raises fault, or idles the tracker with legacy_allow_in
// - fault reports the branch target address
module indirect_branch_tracker (
   // clock and reset
   input wire logic clk_in,
   input wire logic nrst_in,
   // processor mode
   input wire logic master_flow_guard_enable_in,
   input wire logic protected_mode_enable_in,
   input wire logic virtual_8086_flag_in,
   input wire logic long_mode_in,
   input wire logic [1:0] current_privilege_level_in,
   // configuration
   input wire flow_guard_pkg::flow_guard_cfg_t user_flow_guard_config_in,
   input wire flow_guard_pkg::flow_guard_cfg_t supervisor_flow_guard_config_in,
   input wire logic legacy_allow_in,
   // retirement
   input wire logic retire_valid_in,
   input wire flow_guard_pkg::retire_kind_t retire_kind_in,
   input wire logic [1:0] dest_privilege_level_in,
   input wire logic transfer_fault_in,
   input wire logic [63:0] retire_ip_in,
   // status
   output logic tracking_enabled_out,
   output logic tracking_active_out,
   output logic user_tracker_selected_out,
   output flow_guard_pkg::tracker_state_t user_state_out,
   output flow_guard_pkg::tracker_state_t supervisor_state_out,
   output logic [1:0] tracker_bit_a_out,
   // fault report
   output logic control_protection_fault_out,
   output logic [63:0] fault_ip_out
);

   // enable test; with check_tracker_bit_a set it becomes the active test
   function automatic logic tracking_test(input logic mode_ok,
                                          input flow_guard_pkg::flow_guard_cfg_t cfg,
                                          input logic check_tracker_bit_a);
      tracking_test = mode_ok & cfg.enable & ~(check_tracker_bit_a & cfg.tracker_bit_a);
   endfunction : tracking_test

   // configuration of the class a privilege level belongs to
   function automatic flow_guard_pkg::flow_guard_cfg_t pick_cfg(
      input logic [1:0] level,
      input flow_guard_pkg::flow_guard_cfg_t user_cfg,
      input flow_guard_pkg::flow_guard_cfg_t sup_cfg);
      if (level == flow_guard_pkg::USER_PRIVILEGE_LEVEL) begin
         pick_cfg = user_cfg;
      end else begin
         pick_cfg = sup_cfg;
      end
   endfunction : pick_cfg

   flow_guard_pkg::tracker_state_t state [2];
   flow_guard_pkg::tracker_state_t next_state [2];
   logic [1:0] bit_a;
   logic [1:0] next_bit_a;
   logic next_enabled;
   logic next_active;
   logic next_fault;
   logic [63:0] next_fault_ip;

   logic mode_ok;
   logic cur_idx;
   logic dest_idx;
   logic class_change;
   logic pad_ok;
   logic dest_en;
   logic wait_miss;
   flow_guard_pkg::flow_guard_cfg_t sel_cfg;
   flow_guard_pkg::flow_guard_cfg_t dest_cfg;

   // decode of the mode and the retired instruction
   assign mode_ok = master_flow_guard_enable_in & protected_mode_enable_in
                    & ~virtual_8086_flag_in;
   assign cur_idx = (current_privilege_level_in == flow_guard_pkg::USER_PRIVILEGE_LEVEL);
   assign dest_idx = (dest_privilege_level_in == flow_guard_pkg::USER_PRIVILEGE_LEVEL);
   assign class_change = cur_idx != dest_idx;
   assign sel_cfg = pick_cfg(current_privilege_level_in, user_flow_guard_config_in,
                             supervisor_flow_guard_config_in);
   assign dest_cfg = pick_cfg(dest_privilege_level_in, user_flow_guard_config_in,
                              supervisor_flow_guard_config_in);
   assign dest_en = tracking_test(mode_ok, dest_cfg, 1'b0);
   // wrong-width pad counts as missing
   assign pad_ok = long_mode_in
                   ? (retire_kind_in == flow_guard_pkg::RETIRE_LANDING_PAD_64)
                   : (retire_kind_in == flow_guard_pkg::RETIRE_LANDING_PAD_32);
   // events outrank the missing-pad fault, so the waiting state survives them
   assign wait_miss = retire_valid_in & (state[cur_idx] == flow_guard_pkg::await_landing_pad_state)
                      & (retire_kind_in != flow_guard_pkg::RETIRE_EVENT) & ~pad_ok;

   // tracker next state
   always_comb begin
      next_state = state;
      next_bit_a = bit_a;
      next_fault = 1'b0;
      next_fault_ip = fault_ip_out;
      next_enabled = tracking_test(mode_ok, sel_cfg, 1'b0);
      next_active = tracking_test(mode_ok, sel_cfg, 1'b1);
      if (wait_miss) begin
         if (legacy_allow_in) begin
            next_state[cur_idx] = flow_guard_pkg::TRACKER_IDLE;
            next_bit_a[cur_idx] = ~sel_cfg.tracker_bit_a_disable;
         end else begin
            next_fault = 1'b1;
            next_fault_ip = retire_ip_in;
         end
      end else if (retire_valid_in && !transfer_fault_in && dest_en) begin
         case (retire_kind_in)
            flow_guard_pkg::RETIRE_FAR_BRANCH,
            flow_guard_pkg::RETIRE_SYSTEM_ENTRY,
            flow_guard_pkg::RETIRE_EVENT: begin
               next_state[dest_idx] = flow_guard_pkg::await_landing_pad_state;
               next_bit_a[dest_idx] = 1'b0;
            end
            flow_guard_pkg::RETIRE_NEAR_INDIRECT: begin
               if (!dest_cfg.tracker_bit_a && !bit_a[dest_idx]) begin
                  next_state[dest_idx] = flow_guard_pkg::await_landing_pad_state;
               end
            end
            flow_guard_pkg::RETIRE_LANDING_PAD_32,
            flow_guard_pkg::RETIRE_LANDING_PAD_64: begin
               if (pad_ok) begin
                  next_state[cur_idx] = flow_guard_pkg::TRACKER_IDLE;
                  next_bit_a[cur_idx] = 1'b0;
               end
            end
            default: begin
               // returns keep the retained state of whichever tracker resumes
               next_state = state;
            end
         endcase
      end
   end

   // registers; both trackers come up idle
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         state[flow_guard_pkg::TRACKER_SUPERVISOR] <= flow_guard_pkg::RESET_TRACKER_STATE;
         state[flow_guard_pkg::TRACKER_USER] <= flow_guard_pkg::RESET_TRACKER_STATE;
         bit_a <= {2{flow_guard_pkg::RESET_TRACKER_BIT_A}};
         tracking_enabled_out <= 1'b0;
         tracking_active_out <= 1'b0;
         control_protection_fault_out <= 1'b0;
         fault_ip_out <= flow_guard_pkg::RESET_FAULT_IP;
      end else begin
         state <= next_state;
         bit_a <= next_bit_a;
         tracking_enabled_out <= next_enabled;
         tracking_active_out <= next_active;
         control_protection_fault_out <= next_fault;
         fault_ip_out <= next_fault_ip;
      end
   end

   // status views of the trackers
   assign user_tracker_selected_out = cur_idx;
   assign user_state_out = state[flow_guard_pkg::TRACKER_USER];
   assign supervisor_state_out = state[flow_guard_pkg::TRACKER_SUPERVISOR];
   assign tracker_bit_a_out = bit_a;

   // checks on the enable tests
   chk_enable_mode: assert property (@(posedge clk_in) disable iff (!nrst_in)
      tracking_enabled_out |-> $past(mode_ok) && $past(sel_cfg.enable))
      else $error("enabled reported without mode conditions");
   chk_user_select: assert property (@(posedge clk_in) disable iff (!nrst_in)
      $past(nrst_in) && $past(cur_idx)
      |-> tracking_enabled_out == ($past(mode_ok) && $past(user_flow_guard_config_in.enable)))
      else $error("user level did not use user configuration");
   chk_active_test: assert property (@(posedge clk_in) disable iff (!nrst_in)
      tracking_active_out |-> tracking_enabled_out && !$past(sel_cfg.tracker_bit_a))
      else $error("active reported while suppressed");

   // checks on tracker movement
   chk_reset_idle: assert property (@(posedge clk_in)
      $rose(nrst_in) |-> user_state_out == flow_guard_pkg::TRACKER_IDLE
                         && supervisor_state_out == flow_guard_pkg::TRACKER_IDLE)
      else $error("tracker not idle after reset");
   chk_event_wait: assert property (@(posedge clk_in) disable iff (!nrst_in)
      (retire_valid_in && retire_kind_in == flow_guard_pkg::RETIRE_EVENT && !transfer_fault_in
       && dest_en) |=> state[$past(dest_idx)] == flow_guard_pkg::await_landing_pad_state
                       && !bit_a[$past(dest_idx)])
      else $error("event did not arm the destination tracker");
   chk_near_wait: assert property (@(posedge clk_in) disable iff (!nrst_in)
      (retire_valid_in && retire_kind_in == flow_guard_pkg::RETIRE_NEAR_INDIRECT && !wait_miss
       && !transfer_fault_in && dest_en && !dest_cfg.tracker_bit_a && !bit_a[dest_idx])
      |=> state[$past(dest_idx)] == flow_guard_pkg::await_landing_pad_state)
      else $error("near indirect branch did not arm tracker");
   chk_fault_hold: assert property (@(posedge clk_in) disable iff (!nrst_in)
      (retire_valid_in && class_change && transfer_fault_in && !wait_miss)
      |=> $stable(user_state_out) && $stable(supervisor_state_out) && $stable(bit_a))
      else $error("faulted transfer changed a tracker");
   chk_return_keep: assert property (@(posedge clk_in) disable iff (!nrst_in)
      (retire_valid_in && retire_kind_in == flow_guard_pkg::RETIRE_INTERRUPT_RETURN && !wait_miss)
      |=> $stable(user_state_out) && $stable(supervisor_state_out))
      else $error("interrupt return changed a tracker");
   chk_disabled_keep: assert property (@(posedge clk_in) disable iff (!nrst_in)
      (retire_valid_in && !wait_miss && !dest_en) |=> $stable(user_state_out)
                                                      && $stable(supervisor_state_out)
                                                      && $stable(bit_a))
      else $error("disabled level changed a tracker");

   // checks on the fault report
   chk_fault_cause: assert property (@(posedge clk_in) disable iff (!nrst_in)
      control_protection_fault_out |-> $past(wait_miss) && !$past(legacy_allow_in))
      else $error("fault without missing landing pad");
   chk_fault_ip: assert property (@(posedge clk_in) disable iff (!nrst_in)
      control_protection_fault_out |-> fault_ip_out == $past(retire_ip_in))
      else $error("fault address is not the branch target");

endmodule : indirect_branch_tracker

// File: tb/core_model.sv
`timescale 1ns/1ps
// retirement side of the core: one retirement per call
module core_model (
   // clock
   input wire logic clk_in,
   // retirement
   output logic retire_valid_out,
   output flow_guard_pkg::retire_kind_t retire_kind_out,
   output logic [1:0] dest_level_out,
   output logic transfer_fault_out,
   output logic [63:0] retire_ip_out
);
   // quiet lines from time zero
   initial begin
      retire_valid_out = 1'b0;
      retire_kind_out = flow_guard_pkg::RETIRE_OTHER;
      dest_level_out = 2'h0;
      transfer_fault_out = 1'b0;
      retire_ip_out = 64'h0000_0000_0000_0000;
   end
   // held over one rising edge, then released
   task automatic retire(input flow_guard_pkg::retire_kind_t kind, input logic [1:0] dest,
                         input logic flt, input logic [63:0] ip);
      @(negedge clk_in);
      retire_valid_out = 1'b1;
      retire_kind_out = kind;
      dest_level_out = dest;
      transfer_fault_out = flt;
      retire_ip_out = ip;
      @(negedge clk_in);
      retire_valid_out = 1'b0;
      retire_ip_out = ~ip; // stale address must never look valid
   endtask : retire
endmodule : core_model

// File: tb/testbench.sv
`timescale 1ns/1ps
module testbench;
   logic clk_in, nrst_in, master, prot, v86, long_mode, legacy;
   logic valid, flt, en_o, act_o, sel_o, fault_o;
   logic [1:0] current_privilege_level, dest, bit_a;
   logic [63:0] ip, fip, ipv;
   flow_guard_pkg::flow_guard_cfg_t ucfg, scfg;
   flow_guard_pkg::retire_kind_t kind;
   flow_guard_pkg::tracker_state_t ust, sst;
   int error_cnt = 0;
   int compares = 0;
   // core clock, 25 ns period
   initial begin
      clk_in = 1'b0;
      forever #12.5 clk_in = ~clk_in;
   end
   core_model i_core (.clk_in(clk_in), .retire_valid_out(valid), .retire_kind_out(kind),
      .dest_level_out(dest), .transfer_fault_out(flt), .retire_ip_out(ip));
   indirect_branch_tracker i_dut (.clk_in(clk_in), .nrst_in(nrst_in),
      .master_flow_guard_enable_in(master), .protected_mode_enable_in(prot),
      .virtual_8086_flag_in(v86), .long_mode_in(long_mode), .current_privilege_level_in(current_privilege_level),
      .user_flow_guard_config_in(ucfg), .supervisor_flow_guard_config_in(scfg),
      .legacy_allow_in(legacy), .retire_valid_in(valid), .retire_kind_in(kind),
      .dest_privilege_level_in(dest), .transfer_fault_in(flt), .retire_ip_in(ip),
      .tracking_enabled_out(en_o), .tracking_active_out(act_o),
      .user_tracker_selected_out(sel_o), .user_state_out(ust), .supervisor_state_out(sst),
      .tracker_bit_a_out(bit_a), .control_protection_fault_out(fault_o), .fault_ip_out(fip));
   // value compare, any width up to an address
   task automatic check_val(input string name, input logic [63:0] exp, input logic [63:0] got);
      compares++;
      if (got !== exp) begin
         error_cnt++;
         $display("ERROR %s expected %h seen %h", name, exp, got);
      end
   endtask : check_val
   // tracker pair: user in bit 1, supervisor in bit 0
   task automatic check_st(input logic [1:0] exp);
      check_val("states", {62'h0, exp}, {62'h0, ust, sst});
   endtask : check_st
   task automatic rt(input flow_guard_pkg::retire_kind_t k, input logic [1:0] d, input logic f);
      i_core.retire(k, d, f, ipv);
   endtask : rt
   task automatic finish_test();
      $display("compares %0d mismatches %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : finish_test
   // tests run about 140 cycles, so 1000 means a hang
   initial begin
      #25000;
      error_cnt++;
      $display("ERROR watchdog expected done seen hang");
      finish_test();
   end
   initial begin
      nrst_in = 1'b0;
      {master, prot, v86, long_mode, legacy} = 5'h18;
      current_privilege_level = 2'h3;
      ucfg = 3'h4;
      scfg = 3'h4;
      ipv = 64'h0000_0000_0040_1000;
      repeat (12) @(negedge clk_in);
      nrst_in = 1'b1;
      check_st(2'h0);
      check_val("bit_a", 64'h0, {62'h0, bit_a});
      // every mode and user enable/tracker_bit_a mix
      for (int i = 0; i < 32; i++) begin
         @(negedge clk_in);
         {master, prot, v86, ucfg.enable, ucfg.tracker_bit_a} = i[4:0];
         @(negedge clk_in);
         check_val("enabled", i[4] & i[3] & !i[2] & i[1], en_o);
         check_val("active", i[4] & i[3] & !i[2] & i[1] & !i[0], act_o);
      end
      $display("test mode_table done");
      {v86, ucfg, scfg} = 7'h20; // user on, supervisor off
      for (int l = 0; l < 4; l++) begin
         @(negedge clk_in);
         current_privilege_level = l[1:0];
         @(negedge clk_in);
         check_val("enabled", l == 3, en_o);
         check_val("selected", l == 3, sel_o);
      end
      scfg = 3'h4;
      $display("test level_select done");
      // pad width follows mode; the wrong width is no pad at all
      for (int w = 0; w < 2; w++) begin
         long_mode = w[0];
         rt(flow_guard_pkg::RETIRE_NEAR_INDIRECT, 2'h3, 1'b0);
         check_st(2'h2);
         ipv = ipv + 64'h0000_0000_0000_0100;
         rt(flow_guard_pkg::RETIRE_OTHER, 2'h3, 1'b0);
         check_val("fault", 1'b1, fault_o);
         check_val("fault_ip", ipv, fip);
         rt(w ? flow_guard_pkg::RETIRE_LANDING_PAD_32 : flow_guard_pkg::RETIRE_LANDING_PAD_64,
            2'h3, 1'b0);
         check_val("fault", 1'b1, fault_o);
         rt(w ? flow_guard_pkg::RETIRE_LANDING_PAD_64 : flow_guard_pkg::RETIRE_LANDING_PAD_32,
            2'h3, 1'b0);
         check_st(2'h0);
         check_val("fault", 1'b0, fault_o);
      end
      $display("test landing_pad done");
      // suppression stops near branches but not far ones
      ucfg = 3'h6;
      rt(flow_guard_pkg::RETIRE_NEAR_INDIRECT, 2'h3, 1'b0);
      check_st(2'h0);
      rt(flow_guard_pkg::RETIRE_FAR_BRANCH, 2'h3, 1'b0);
      check_st(2'h2);
      ucfg = 3'h4;
      rt(flow_guard_pkg::RETIRE_EVENT, 2'h0, 1'b0);
      check_st(2'h3);
      current_privilege_level = 2'h0;
      rt(flow_guard_pkg::RETIRE_LANDING_PAD_64, 2'h0, 1'b0);
      check_st(2'h2);
      rt(flow_guard_pkg::RETIRE_INTERRUPT_RETURN, 2'h3, 1'b0);
      check_st(2'h2);
      current_privilege_level = 2'h3;
      rt(flow_guard_pkg::RETIRE_OTHER, 2'h3, 1'b0);
      check_val("fault", 1'b1, fault_o);
      rt(flow_guard_pkg::RETIRE_LANDING_PAD_64, 2'h3, 1'b0);
      $display("test privilege_change done");
      // faulted transfer, system entry, same-class return, disabled target
      rt(flow_guard_pkg::RETIRE_FAR_BRANCH, 2'h0, 1'b1);
      check_st(2'h0);
      rt(flow_guard_pkg::RETIRE_SYSTEM_ENTRY, 2'h0, 1'b0);
      check_st(2'h1);
      current_privilege_level = 2'h0;
      rt(flow_guard_pkg::RETIRE_LANDING_PAD_64, 2'h0, 1'b0);
      rt(flow_guard_pkg::RETIRE_INTERRUPT_RETURN, 2'h0, 1'b0);
      check_st(2'h0);
      scfg = 3'h0;
      rt(flow_guard_pkg::RETIRE_EVENT, 2'h0, 1'b0);
      check_st(2'h0);
      $display("test transfers done");
      // legacy treatment: no fault, tracker idles, suppression from its config
      current_privilege_level = 2'h3;
      legacy = 1'b1;
      ucfg = 3'h5;
      rt(flow_guard_pkg::RETIRE_NEAR_INDIRECT, 2'h3, 1'b0);
      rt(flow_guard_pkg::RETIRE_OTHER, 2'h3, 1'b0);
      check_val("fault", 1'b0, fault_o);
      check_val("bit_a", 64'h0, {62'h0, bit_a});
      ucfg = 3'h4;
      rt(flow_guard_pkg::RETIRE_FAR_BRANCH, 2'h3, 1'b0);
      rt(flow_guard_pkg::RETIRE_OTHER, 2'h3, 1'b0);
      check_st(2'h0);
      check_val("bit_a", 64'h2, {62'h0, bit_a});
      rt(flow_guard_pkg::RETIRE_NEAR_INDIRECT, 2'h3, 1'b0);
      check_st(2'h0);
      scfg = 3'h4;
      rt(flow_guard_pkg::RETIRE_EVENT, 2'h0, 1'b0);
      check_st(2'h1);
      check_val("bit_a", 64'h2, {62'h0, bit_a});
      // reset in mid-run: both trackers and their suppression go back to idle
      nrst_in = 1'b0;
      repeat (2) @(negedge clk_in);
      nrst_in = 1'b1;
      check_st(2'h0);
      check_val("bit_a", 64'h0, {62'h0, bit_a});
      check_val("enabled", 1'b0, en_o);
      @(negedge clk_in);
      check_val("enabled", 1'b1, en_o);
      rt(flow_guard_pkg::RETIRE_NEAR_INDIRECT, 2'h3, 1'b0);
      check_st(2'h2);
      $display("test legacy_reset done");
      finish_test();
   end
endmodule : testbench
